//--- hw/windowed_watchdog_down_counter.sv
/*
 * Windowed watchdog down-counter with APB register access, halt handling
 * and timeout bound readback.
 * Assumes the APB clock is the halved oscillator clock, that halt, wake and
 * interrupt inputs are one-cycle pulses synchronous to pclk, and that the
 * chip reset network watches reset_pin_n.
 */
// How it works
// RULE1 - Software writes keep counter bit six set.
// RULE2 - Counter steps down every 16384 clocks.
// RULE3 - Active step from 40h to 3Fh resets.
// RULE4 - Activation set by software, cleared by reset.
// RULE5 - Inactive watchdog never resets the chip; the code still resets it on halt with the halt-reset option.
// RULE6 - Control register resets to 7Fh.
// RULE7 - Hardware option keeps watchdog always active.
// RULE8 - Slow and wait modes change nothing.
// RULE9 - Plain halt: one step, then frozen.
// RULE10 - External wake: resume after 256/4096 clocks.
// RULE11 - Reset ends plain halt: reset state.
// RULE12 - Halt with halt-reset option resets chip.
// RULE13 - Active-halt freezes, interrupt resumes at once.
// RULE14 - Reset ends active-halt: delayed restart.
// RULE15 - Software reloads counter before halting.
// RULE16 - Timeout bounds use timebase constant pairs.
// RULE17 - Bound formulas with floor divisions.
// RULE18 - Counter runs even when not activated.
// RULE19 - Watchdog reset pulls pin low 30us.
// RULE20 - Activation one, bit six zero forces reset.
// RULE21 - Writes load counter, reads return it.
module windowed_watchdog_down_counter #(
    parameter int unsigned PRESCALE = wdg_pkg::PRESCALE_CYCLES
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        halt_exec,
    input  wire logic        ext_irq,
    input  wire logic        osc_irq,
    input  wire logic        wake_reset,
    output logic             reset_pin_n,
    output logic             watchdog_active
);

    localparam int unsigned PW = $clog2(PRESCALE) + 1;

    // ------------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------------

    // Maps a byte address onto a register selection.
    function automatic wdg_pkg::sel_t reg_sel(input logic [7:0] addr);
        reg_sel = wdg_pkg::SEL_NONE;
        if (addr[1:0] == 2'h0) begin
            if (addr[7:2] == wdg_pkg::CTRL_IDX[5:0]) begin
                reg_sel = wdg_pkg::SEL_CTRL;
            end else if (addr[7:2] == wdg_pkg::CFG_IDX[5:0]) begin
                reg_sel = wdg_pkg::SEL_CFG;
            end else if (addr[7:2] == wdg_pkg::STAT_IDX[5:0]) begin
                reg_sel = wdg_pkg::SEL_STAT;
            end else if (addr[7:2] == wdg_pkg::TMIN_IDX[5:0]) begin
                reg_sel = wdg_pkg::SEL_TMIN;
            end else if (addr[7:2] == wdg_pkg::TMAX_IDX[5:0]) begin
                reg_sel = wdg_pkg::SEL_TMAX;
            end
        end
    endfunction

    // Timeout bound in half-oscillator periods for a step count.
    function automatic logic [31:0] timeout(
        input logic [5:0] steps,
        input logic [1:0] tb,
        input logic       upper
    );
        logic [31:0] msb;
        logic [31:0] lsb;
        logic [31:0] c;
        logic [31:0] q;
        logic [31:0] base;
        logic        short_range;
        msb  = wdg_pkg::TB_MSB[tb];                                 // see RULE16
        lsb  = wdg_pkg::TB_LSB[tb];
        c    = {26'h0, steps};
        q    = (c * 32'h4) / msb;                                   // see RULE17
        base = upper ? wdg_pkg::TMAX_BASE
                     : (lsb + wdg_pkg::TMIN_ADD) * wdg_pkg::STEP_MUL;
        short_range = upper ? (c <= msb / 32'h4) : (c < msb / 32'h4);
        if (short_range) begin
            timeout = base + wdg_pkg::TMAX_BASE * c;
        end else begin
            timeout = base + wdg_pkg::TMAX_BASE * (c - q)
                    + (wdg_pkg::LONG_ADD + lsb) * wdg_pkg::STEP_MUL * q;
        end
    endfunction

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic                   act_q;
    logic                   act_d;
    logic [6:0]             cnt_q;
    logic [6:0]             cnt_d;
    logic [PW-1:0]          presc_q;
    logic [PW-1:0]          presc_d;
    wdg_pkg::mode_t         mode_q;
    wdg_pkg::mode_t         mode_d;
    logic [12:0]            dly_q;
    logic [12:0]            dly_d;
    logic [11:0]            pulse_q;
    logic [11:0]            pulse_d;
    logic [wdg_pkg::CFG_W-1:0] cfg_q;
    logic [wdg_pkg::CFG_W-1:0] cfg_d;
    logic                   pin_d;
    logic                   active_d;
    logic [31:0]            prdata_d;
    logic                   pready_d;
    logic                   pslverr_d;

    logic                   active;
    logic                   fire;
    logic                   setup;
    logic                   wr_en;
    wdg_pkg::sel_t          sel;
    logic [12:0]            wake_len;
    logic [1:0]             tb;

    // Bus phase and watchdog enable decoding.
    assign sel      = reg_sel(paddr);
    assign setup    = psel & ~penable;
    assign wr_en    = psel & penable & pready & pwrite & pstrb[0];
    assign active   = act_q | cfg_q[wdg_pkg::CFG_HW_BIT];               // see RULE7
    assign tb       = cfg_q[wdg_pkg::CFG_TB_LO +: 2];
    assign wake_len = cfg_q[wdg_pkg::CFG_LONG_BIT] ? wdg_pkg::WAKE_LONG
                                                   : wdg_pkg::WAKE_SHORT;

    // ------------------------------------------------------------------
    // Watchdog core
    // ------------------------------------------------------------------

    // Next state of counter, prescaler, mode, wake delay and reset pulse.
    // Slow and wait modes have no input here: counting goes on as in run.
    always_comb begin
        act_d   = act_q;
        cnt_d   = cnt_q;
        presc_d = presc_q;
        mode_d  = mode_q;
        dly_d   = dly_q;
        pulse_d = pulse_q;
        cfg_d   = cfg_q;
        fire    = 1'b0;

        // Free-running decrement, whatever the activation state.
        if (mode_q == wdg_pkg::MODE_RUN) begin                          // see RULE8
            if (presc_q == PW'(PRESCALE - 1)) begin                     // see RULE2
                presc_d = '0;
                cnt_d   = cnt_q - 7'h01;                                // see RULE18
                if (active && cnt_q == 7'h40) begin                     // see RULE3
                    fire = 1'b1;                                        // see RULE5
                end
            end else begin
                presc_d = presc_q + PW'(1);
            end
        end

        // Software access to the control and configuration registers.
        if (wr_en && sel == wdg_pkg::SEL_CTRL) begin
            act_d = act_q | pwdata[7];                                  // see RULE4
            cnt_d = pwdata[6:0];                                        // see RULE21
            if (!pwdata[6] && (pwdata[7] || active)) begin              // see RULE20
                fire = 1'b1;                                            // see RULE1
            end
        end
        if (wr_en && sel == wdg_pkg::SEL_CFG) begin
            cfg_d = pwdata[wdg_pkg::CFG_W-1:0];
        end

        // Halt entry, wake-up and wake delay sequencing.
        unique case (mode_q)
            wdg_pkg::MODE_RUN: begin
                if (halt_exec) begin
                    if (cfg_q[wdg_pkg::CFG_RTC_BIT]) begin
                        mode_d = wdg_pkg::MODE_ACTIVE_HALT;             // see RULE13
                        cnt_d  = cnt_q;
                    end else if (cfg_q[wdg_pkg::CFG_HALT_BIT]) begin
                        fire = 1'b1;                                    // see RULE12
                    end else begin
                        mode_d  = wdg_pkg::MODE_HALT;                   // see RULE9
                        cnt_d   = cnt_q - 7'h01;
                        presc_d = '0;
                    end
                end
            end
            wdg_pkg::MODE_HALT: begin
                if (wake_reset) begin
                    act_d   = 1'b0;                                     // see RULE11
                    cnt_d   = wdg_pkg::CTRL_RESET[6:0];
                    presc_d = '0;
                    mode_d  = wdg_pkg::MODE_RUN;
                end else if (ext_irq) begin
                    mode_d = wdg_pkg::MODE_WAKE_DELAY;                  // see RULE10
                    dly_d  = wake_len;
                end
            end
            wdg_pkg::MODE_ACTIVE_HALT: begin
                if (wake_reset) begin
                    act_d   = 1'b0;
                    cnt_d   = wdg_pkg::CTRL_RESET[6:0];
                    presc_d = '0;
                    mode_d  = wdg_pkg::MODE_WAKE_DELAY;                 // see RULE14
                    dly_d   = wake_len;
                end else if (ext_irq || osc_irq) begin
                    mode_d = wdg_pkg::MODE_RUN;                         // see RULE13
                end
            end
            wdg_pkg::MODE_WAKE_DELAY: begin
                dly_d = dly_q - 13'h0001;
                if (dly_q == 13'h0001) begin
                    mode_d = wdg_pkg::MODE_RUN;
                end
            end
        endcase

        // Reset pulse; a new cause during a pulse is absorbed by it.
        if (pulse_q != 12'h000) begin
            pulse_d = pulse_q - 12'h001;
        end else if (fire) begin
            pulse_d = wdg_pkg::PULSE_CYCLES;                            // see RULE19
            act_d   = 1'b0;                                             // see RULE6
            cnt_d   = wdg_pkg::CTRL_RESET[6:0];
            presc_d = '0;
            mode_d  = wdg_pkg::MODE_RUN;
        end

        pin_d    = (pulse_d == 12'h000);
        active_d = act_d | cfg_d[wdg_pkg::CFG_HW_BIT];
    end

    // Core registers.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            act_q           <= 1'b0;
            cnt_q           <= wdg_pkg::CTRL_RESET[6:0];
            presc_q         <= '0;
            mode_q          <= wdg_pkg::MODE_RUN;
            dly_q           <= 13'h0000;
            pulse_q         <= 12'h000;
            cfg_q           <= wdg_pkg::CFG_RESET;
            reset_pin_n     <= 1'b1;
            watchdog_active <= 1'b0;
        end else begin
            act_q           <= act_d;
            cnt_q           <= cnt_d;
            presc_q         <= presc_d;
            mode_q          <= mode_d;
            dly_q           <= dly_d;
            pulse_q         <= pulse_d;
            cfg_q           <= cfg_d;
            reset_pin_n     <= pin_d;
            watchdog_active <= active_d;
        end
    end

    // ------------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------------

    // Read data and answer are prepared in the setup cycle, one wait-free
    // access phase follows. Unmapped addresses answer with an error.
    always_comb begin
        prdata_d  = 32'h0000_0000;
        pready_d  = setup;
        pslverr_d = setup & (sel == wdg_pkg::SEL_NONE);
        if (setup && !pwrite) begin
            unique case (sel)
                wdg_pkg::SEL_CTRL: prdata_d = {24'h0, act_q, cnt_q};    // see RULE21
                wdg_pkg::SEL_CFG:  prdata_d = {26'h0, cfg_q};
                wdg_pkg::SEL_STAT: prdata_d = {28'h0, pulse_q != 12'h000,
                                               active, mode_q};
                wdg_pkg::SEL_TMIN: prdata_d = timeout(cnt_q[5:0], tb, 1'b0);
                wdg_pkg::SEL_TMAX: prdata_d = timeout(cnt_q[5:0], tb, 1'b1);
                wdg_pkg::SEL_NONE: prdata_d = 32'h0000_0000;
                default:           prdata_d = 32'h0000_0000;
            endcase
        end
    end

    // Bus registers.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            prdata  <= prdata_d;
            pready  <= pready_d;
            pslverr <= pslverr_d;
        end
    end

endmodule

//--- hw/wdg_pkg.sv
/*
 * Constants, types and register map of the windowed watchdog down-counter.
 * Assumes a 125 MHz APB clock that also serves as the halved oscillator clock
 * and as the CPU clock used for wake-up delays.
 */
package wdg_pkg;

    // ------------------------------------------------------------------
    // Register map: indices, byte address is four times the index.
    // ------------------------------------------------------------------
    localparam logic [7:0] CTRL_IDX  = 8'h2A;
    localparam logic [7:0] CFG_IDX   = 8'h2B;
    localparam logic [7:0] STAT_IDX  = 8'h2E;
    localparam logic [7:0] TMIN_IDX  = 8'h30;
    localparam logic [7:0] TMAX_IDX  = 8'h31;
    localparam logic [7:0] CTRL_RESET = 8'h7F;

    // Configuration register fields.
    localparam int unsigned CFG_HW_BIT    = 0;
    localparam int unsigned CFG_HALT_BIT  = 1;
    localparam int unsigned CFG_RTC_BIT   = 2;
    localparam int unsigned CFG_TB_LO     = 3;
    localparam int unsigned CFG_LONG_BIT  = 5;
    localparam int unsigned CFG_W         = 6;
    localparam logic [5:0]  CFG_RESET     = 6'h00;

    // ------------------------------------------------------------------
    // Timing.
    // ------------------------------------------------------------------
    localparam int unsigned PRESCALE_CYCLES = 32'h0000_4000;
    localparam logic [12:0] WAKE_SHORT      = 13'h0100;
    localparam logic [12:0] WAKE_LONG       = 13'h1000;
    localparam int unsigned CLK_PERIOD_NS   = 32'h0000_0008;
    localparam int unsigned RESET_PULSE_US  = 32'h0000_001E;
    localparam logic [11:0] PULSE_CYCLES    =
        12'((RESET_PULSE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // Timeout formula constants, indexed by timebase selection.
    localparam logic [31:0] TB_MSB [4] = '{32'h04, 32'h08, 32'h14, 32'h31};
    localparam logic [31:0] TB_LSB [4] = '{32'h3B, 32'h35, 32'h23, 32'h36};
    localparam logic [31:0] TMIN_ADD  = 32'h0000_0080;
    localparam logic [31:0] STEP_MUL  = 32'h0000_0040;
    localparam logic [31:0] TMAX_BASE = 32'h0000_4000;
    localparam logic [31:0] LONG_ADD  = 32'h0000_00C0;

    typedef enum logic [1:0] {
        MODE_RUN,
        MODE_HALT,
        MODE_ACTIVE_HALT,
        MODE_WAKE_DELAY
    } mode_t;

    typedef enum logic [2:0] {
        SEL_NONE,
        SEL_CTRL,
        SEL_CFG,
        SEL_STAT,
        SEL_TMIN,
        SEL_TMAX
    } sel_t;

endpackage

//--- verification/wdg_assertions.sv
/* Checker for the watchdog: APB answer timing and the reset pulse.
   Sees only the top module's ports; bound to every instance below. */
module wdg_assertions #(
    parameter int unsigned PRESCALE = 16384
) (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        halt_exec,
    input wire logic        ext_irq,
    input wire logic        osc_irq,
    input wire logic        wake_reset,
    input wire logic        reset_pin_n,
    input wire logic        watchdog_active
);
    timeunit 1ns;
    timeprecision 1ps;

    // Write strobes of the control and configuration registers.
    wire acc    = psel && penable && pready && pwrite && pstrb[0];
    wire ctl_wr = acc && paddr == 8'hA8;
    wire cfg_wr = acc && paddr == 8'hAC;
    wire mapped = paddr inside {8'hA8, 8'hAC, 8'hB8, 8'hC0, 8'hC4};
    logic [12:0] low_q;
    logic [12:0] low_d;

    // Counts the cycles of the current reset pulse.
    always_comb low_d = reset_pin_n ? 13'h0000 : low_q + 13'h0001;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) low_q <= 13'h0000;
        else low_q <= low_d;
    end

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("pready missing after setup");
    a_ready_in_access: assert property (pready |-> psel && penable && $past(psel && !penable))
        else $error("pready outside access");
    a_err_unmapped: assert property (pready || pslverr |-> pready && pslverr == !mapped)
        else $error("pslverr wrong");
    a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
        else $error("prdata not zero when idle");
    a_soft_reset: assert property (ctl_wr && pwdata[7:6] == 2'b10 && reset_pin_n |=> !reset_pin_n)
        else $error("forced reset missing");
    a_reset_cause: assert property ($fell(reset_pin_n) |-> $past(watchdog_active || halt_exec || ctl_wr))
        else $error("reset while inactive");
    a_active_sticky: assert property (watchdog_active && reset_pin_n && !cfg_wr && !wake_reset |=> watchdog_active || !reset_pin_n)
        else $error("activation lost");
    a_pulse_length: assert property ($rose(reset_pin_n) |-> low_q == 13'h0EA6)
        else $error("reset pulse length wrong");
endmodule

bind windowed_watchdog_down_counter wdg_assertions #(.PRESCALE(PRESCALE)) u_wdg_assertions (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .halt_exec(halt_exec), .ext_irq(ext_irq), .osc_irq(osc_irq),
    .wake_reset(wake_reset), .reset_pin_n(reset_pin_n), .watchdog_active(watchdog_active));

//--- verification/windowed_watchdog_down_counter_tb.sv
/* Self-checking bench for the watchdog block.
   Drives APB and the halt and wake pulses from one 125 MHz clock. */
module windowed_watchdog_down_counter_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] MSB_T [4] = '{32'h04, 32'h08, 32'h14, 32'h31};
    localparam logic [31:0] LSB_T [4] = '{32'h3B, 32'h35, 32'h23, 32'h36};
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [3:0]  evt = 4'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        reset_pin_n;
    logic        watchdog_active;
    logic [31:0] r;
    logic [31:0] r1;
    logic        err;
    int          fails = 0;
    int          cmp_count = 0;

    windowed_watchdog_down_counter #(.PRESCALE(8)) u_windowed_watchdog_down_counter (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .halt_exec(evt[3]), .ext_irq(evt[2]), .osc_irq(evt[1]),
        .wake_reset(evt[0]), .reset_pin_n(reset_pin_n), .watchdog_active(watchdog_active));

    // Clock of 8 ns period.
    always #4 pclk = ~pclk;

    // Expected timeout bound in half oscillator periods.
    function automatic logic [31:0] bound(input logic [5:0] c, input int t, input logic up);
        logic [31:0] q;
        logic [31:0] b;
        q = (32'h4 * c) / MSB_T[t];
        b = up ? 32'h4000 : (LSB_T[t] + 32'h80) * 32'h40;
        if (up ? (c <= MSB_T[t] / 4) : (c < MSB_T[t] / 4)) return b + 32'h4000 * c;
        return b + 32'h4000 * (c - q) + (32'hC0 + LSB_T[t]) * 32'h40 * q;
    endfunction

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // One APB transfer; read data and error are taken at the edge that sees pready high.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        r = prdata;
        err = pslverr;
        if (pready !== 1'b1) chk("pready", 32'h1, 32'h0);
        {psel, penable} <= 2'b00;
    endtask

    task automatic kick(input logic [3:0] m);
        @(posedge pclk);
        evt <= m;
        @(posedge pclk);
        evt <= 4'h0;
    endtask

    task automatic pin_is(input logic lvl, input int lim);
        int n;
        n = 0;
        while (reset_pin_n !== lvl && n < lim) begin
            @(negedge pclk);
            n++;
        end
        chk("reset_pin_n", {31'h0, lvl}, {31'h0, reset_pin_n});
    endtask

    task automatic t_reset();
        apb(1'b0, 8'hA8, 32'h0);
        chk("ctrl", 32'h7F, r);
        chk("active", 32'h0, {31'h0, watchdog_active});
        apb(1'b0, 8'h00, 32'h0);
        chk("unmapped", 32'h1, {31'h0, err});
    endtask

    task automatic t_count();
        apb(1'b1, 8'hA8, 32'h7F);
        repeat (80) @(posedge pclk);
        apb(1'b0, 8'hA8, 32'h0);
        chk("steps", 32'h1, {31'h0, r[6:0] inside {7'h74, 7'h75, 7'h76}});
        repeat (600) @(posedge pclk);
        chk("reset_pin_n", 32'h1, {31'h0, reset_pin_n});
    endtask

    task automatic t_timeout();
        int n;
        n = 0;
        apb(1'b1, 8'hA8, 32'hC2);
        apb(1'b1, 8'hA8, 32'h42);
        apb(1'b0, 8'hA8, 32'h0);
        chk("act", 32'h1, {31'h0, r[7]});
        chk("load", 32'h1, {31'h0, r[6:0] inside {7'h42, 7'h41}});
        pin_is(1'b0, 40);
        while (reset_pin_n === 1'b0 && n < 4000) begin
            @(negedge pclk);
            n++;
        end
        chk("pulse", 32'hEA6, n);
        apb(1'b0, 8'hA8, 32'h0);
        chk("act", 32'h0, {31'h0, r[7]});
    endtask

    task automatic t_soft_hw();
        apb(1'b1, 8'hA8, 32'h80);
        pin_is(1'b0, 2);
        pin_is(1'b1, 4000);
        apb(1'b1, 8'hAC, 32'h01);
        @(negedge pclk);
        chk("active", 32'h1, {31'h0, watchdog_active});
        pin_is(1'b0, 1100);
        pin_is(1'b1, 4000);
        apb(1'b1, 8'hAC, 32'h02);
        kick(4'h8);
        pin_is(1'b0, 3);
        pin_is(1'b1, 4000);
        apb(1'b1, 8'hAC, 32'h00);
    endtask

    task automatic t_halt();
        apb(1'b1, 8'hA8, 32'hC5);
        kick(4'h8);
        apb(1'b0, 8'hA8, 32'h0);
        r1 = r;
        apb(1'b0, 8'hB8, 32'h0);
        chk("status", 32'h5, r);
        repeat (150) @(posedge pclk);
        apb(1'b0, 8'hA8, 32'h0);
        chk("frozen", r1, r);
        chk("reset_pin_n", 32'h1, {31'h0, reset_pin_n});
        kick(4'h4);
        repeat (150) @(posedge pclk);
        apb(1'b0, 8'hA8, 32'h0);
        chk("delayed", r1, r);
        pin_is(1'b0, 400);
        pin_is(1'b1, 4000);
        apb(1'b1, 8'hA8, 32'hFF);
        kick(4'h8);
        kick(4'h1);
        apb(1'b0, 8'hA8, 32'h0);
        chk("ctrl", 32'h7F, r);
        chk("active", 32'h0, {31'h0, watchdog_active});
    endtask

    task automatic t_active_halt();
        apb(1'b1, 8'hAC, 32'h04);
        kick(4'h8);
        apb(1'b0, 8'hA8, 32'h0);
        r1 = r;
        repeat (100) @(posedge pclk);
        apb(1'b0, 8'hA8, 32'h0);
        chk("frozen", r1, r);
        for (int t = 0; t < 4; t++) begin
            apb(1'b1, 8'hAC, {27'h0, t[1:0], 3'h4});
            apb(1'b0, 8'hC0, 32'h0);
            chk("tmin", bound(r1[5:0], t, 1'b0), r);
            apb(1'b0, 8'hC4, 32'h0);
            chk("tmax", bound(r1[5:0], t, 1'b1), r);
        end
        kick(4'h2);
        repeat (24) @(posedge pclk);
        apb(1'b0, 8'hA8, 32'h0);
        chk("resumed", 32'h1, {31'h0, r[6:0] != r1[6:0]});
        kick(4'h8);
        kick(4'h1);
        apb(1'b0, 8'hA8, 32'h0);
        chk("ctrl", 32'h7F, r);
        repeat (150) @(posedge pclk);
        apb(1'b0, 8'hA8, 32'h0);
        chk("ctrl", 32'h7F, r);
        repeat (200) @(posedge pclk);
        apb(1'b0, 8'hA8, 32'h0);
        chk("restart", 32'h1, {31'h0, r[6:0] != 7'h7F});
    endtask

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Watchdog on the run itself.
    initial begin
        repeat (40000) @(posedge pclk);
        fails++;
        print_verdict();
    end

    // Reset for 8 cycles, then the scenarios.
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_count();
        t_timeout();
        t_soft_hw();
        t_halt();
        t_active_halt();
        print_verdict();
    end
endmodule
